// File: design/lpbp_pkg.sv
package lpbp_pkg;
  // local bus geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 32;
  localparam int LANES  = 4;

  // word indexes of the device's own registers on the local bus
  localparam logic [12:0] CFG_IDX  = 13'h0100;
  localparam logic [12:0] LIRQ_IDX = 13'h0101;
  localparam logic [12:0] HIRQ_IDX = 13'h0102;
  localparam int          MEM_BIT  = 12;

  // local bus configuration word: field positions and value after reset
  localparam int CFG_SEL_HI   = 0;
  localparam int CFG_ALE_LO   = 1;
  localparam int CFG_STB_HI   = 2;
  localparam int CFG_RW_LSB   = 3;
  localparam int CFG_BL_HI    = 5;
  localparam int CFG_BL_LAST  = 6;
  localparam int CFG_RDY_HI   = 7;
  localparam int CFG_RDY_DRV  = 8;
  localparam int CFG_BE_ENC   = 9;
  localparam int CFG_IRQ_HI   = 10;
  localparam int CFG_RIN_HI   = 11;
  localparam int CFG_MUX      = 12;
  localparam int CFG_IRQIN_HI = 13;
  localparam int CFG_TST_RDY  = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // interrupt control words: status bit and mask bit
  localparam int IRQ_STAT_BIT = 0;
  localparam int IRQ_MASK_BIT = 8;

  // meaning of the write and read pins
  localparam logic [1:0] RW_WRITE_DIR = 2'h0;  // write pin high = write
  localparam logic [1:0] RW_READ_DIR  = 2'h1;  // read pin high = read
  localparam logic [1:0] RW_SEPARATE  = 2'h2;  // separate active-low strobes

  // controller register offsets on apb
  localparam logic [7:0] H_CMD   = 8'h00;
  localparam logic [7:0] H_ADDR  = 8'h04;
  localparam logic [7:0] H_WDATA = 8'h08;
  localparam logic [7:0] H_RDATA = 8'h0c;
  localparam logic [7:0] H_STAT  = 8'h10;
  localparam logic [7:0] H_PINS  = 8'h14;

  typedef enum logic {DS_IDLE, DS_DATA} lpbp_dev_state_t;
  typedef enum logic [2:0] {HS_IDLE, HS_ALE, HS_STB, HS_DATA, HS_END} lpbp_host_state_t;

  // active level of a pin under a programmable polarity
  function automatic logic lvl(input logic pin, input logic actHigh);
    lvl = actHigh ? pin : ~pin;
  endfunction : lvl

  // byte lanes from direct active-low enables or size plus offset
  function automatic logic [3:0] laneDecode(input logic [3:0] be, input logic enc);
    logic [3:0] mask;
    mask = 4'hf;
    if (!enc) begin
      laneDecode = ~be;
    end else begin
      case (be[1:0])
        2'h1:    mask = 4'h1;
        2'h2:    mask = 4'h3;
        2'h3:    mask = 4'h7;
        default: mask = 4'hf;
      endcase
      laneDecode = 4'((mask << be[3:2]));
    end
  endfunction : laneDecode

  // merge a write into a word by byte lanes
  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] lanes);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = lanes[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
    mergeLanes = old;
  endfunction : mergeLanes
endpackage : lpbp_pkg

// File: design/lpbp_if.sv
`timescale 1ns/1ps
interface lpbp_if;
  logic        sel;
  logic        ale;
  logic        strobe;
  logic        wrPin;
  logic        rdPin;
  logic        burstLastIn;
  logic        rdyIn;
  logic [3:0]  localByteLaneEn;
  logic [12:0] adr;
  logic [31:0] hostDqOut;
  logic        hostDqOe;
  logic [31:0] devDqOut;
  logic        devDqOe;
  logic [31:0] dq;
  logic        rdyOutVal;
  logic        rdyOutOe;
  logic        rdyLine;
  logic        irqOutVal;
  logic        irqOutOe;
  logic        irqLine;
  logic        irqIn;
  logic        testMode;
  logic        heldResetOut;
  logic        heldResetOut_n;

  // wire levels: floating ready and irq lines are pulled high, a floating data bus reads zero
  assign dq      = devDqOe ? devDqOut : (hostDqOe ? hostDqOut : 32'h0000_0000);
  assign rdyLine = rdyOutOe ? rdyOutVal : 1'b1;
  assign irqLine = irqOutOe ? irqOutVal : 1'b1;

  modport dev (
    input  sel, ale, strobe, wrPin, rdPin, burstLastIn, rdyIn, localByteLaneEn, adr, dq,
    input  irqIn, testMode,
    output devDqOut, devDqOe, rdyOutVal, rdyOutOe, irqOutVal, irqOutOe,
    output heldResetOut, heldResetOut_n
  );
  modport host (
    output sel, ale, strobe, wrPin, rdPin, burstLastIn, rdyIn, localByteLaneEn, adr,
    output hostDqOut, hostDqOe, irqIn, testMode,
    input  dq, rdyLine, irqLine, heldResetOut
  );
endinterface : lpbp_if

// File: design/lpbp_lane_ram.sv
`timescale 1ns/1ps
module lpbp_lane_ram
  import lpbp_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input  wire logic                     mclk,
  input  wire logic                     we,
  input  wire logic [3:0]               lanes,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [31:0]              wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [31:0]              rdata
);
  logic [31:0] mem [DEPTH];

  // byte-lane write, no reset on the array
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= mergeLanes(mem[waddr], wdata, lanes);
    end
  end

  // asynchronous read port
  assign rdata = mem[raddr];
endmodule : lpbp_lane_ram

// File: design/lpbp_device.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module lpbp_device
  import lpbp_pkg::*;
#(
  parameter int MEM_DEPTH = 64
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  lpbp_if.dev             bus,
  input  wire logic       pciBusClk,
  input  wire logic       pciBusReset_n,
  input  wire logic       hostEvent,
  input  wire logic       hostReleaseReset,
  output logic [2:0]      busClockCopyOut,
  output logic            busResetCopyOut_n,
  output logic            intaOe
);
  localparam int MA_W = $clog2(MEM_DEPTH);

  lpbp_dev_state_t state_ff;
  logic [31:0] cfg_ff;
  logic [31:0] lirq_ff;
  logic [31:0] hirq_ff;
  logic        alePrev_ff;
  logic [12:0] latched_ff;
  logic [12:0] addr_ff;
  logic        wr_ff;
  logic [3:0]  lanes_ff;
  logic [31:0] dqOut_ff;
  logic        dqOe_ff;
  logic        rdyVal_ff;
  logic        rdyOe_ff;
  logic        irqVal_ff;
  logic        irqOe_ff;
  logic        intaOe_ff;
  logic [2:0]  clkCopy_ff;
  logic        rstCopy_n_ff;
  logic        held_ff;

  logic        selAct, aleAct, stbAct, rinAct, blAct, isWr, testFloat;
  logic        addrPhase, complete, lastBeat, writeHit;
  logic [12:0] pinAddr, phaseAddr, rdAddr;
  logic [31:0] ramRd, rdWord;
  lpbp_dev_state_t nxt_state;

  // pin decode under the programmable polarities
  assign selAct  = lvl(bus.sel, cfg_ff[CFG_SEL_HI]);
  assign aleAct  = lvl(bus.ale, ~cfg_ff[CFG_ALE_LO]);
  assign stbAct  = lvl(bus.strobe, cfg_ff[CFG_STB_HI]);
  assign rinAct  = lvl(bus.rdyIn, cfg_ff[CFG_RIN_HI]);
  assign blAct   = lvl(bus.burstLastIn, cfg_ff[CFG_BL_HI]);
  assign pinAddr = cfg_ff[CFG_MUX] ? bus.dq[14:2] : bus.adr;
  assign testFloat = bus.testMode && !bus.rdPin;

  // direction from the write and read pins
  always_comb begin
    case (cfg_ff[CFG_RW_LSB +: 2])
      RW_WRITE_DIR: isWr = bus.wrPin;
      RW_READ_DIR:  isWr = !bus.rdPin;
      RW_SEPARATE:  isWr = !bus.wrPin && bus.rdPin;
      default:      isWr = bus.wrPin;
    endcase
  end

  // latch enable active or just falling means the pins hold the address
  assign phaseAddr = (aleAct || alePrev_ff) ? pinAddr : latched_ff;
  assign addrPhase = (state_ff == DS_IDLE) && selAct && stbAct;
  assign complete  = (state_ff == DS_DATA) && selAct && rinAct;
  assign lastBeat  = cfg_ff[CFG_BL_LAST] ? blAct : !blAct;
  assign writeHit  = complete && wr_ff;

  // address latch on the trailing edge of latch enable
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alePrev_ff <= 1'b0;
      latched_ff <= '0;
    end else begin
      alePrev_ff <= aleAct;
      if (alePrev_ff && !aleAct) begin
        latched_ff <= pinAddr;
      end
    end
  end

  // access sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DS_IDLE: if (addrPhase) nxt_state = DS_DATA;
      DS_DATA: begin
        if (!selAct || (complete && lastBeat)) begin
          nxt_state = DS_IDLE;
        end
      end
      default: nxt_state = DS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= DS_IDLE;
      addr_ff  <= '0;
      wr_ff    <= 1'b0;
      lanes_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (addrPhase) begin
        addr_ff  <= phaseAddr;
        wr_ff    <= isWr;
        lanes_ff <= laneDecode(bus.localByteLaneEn, cfg_ff[CFG_BE_ENC]);
      end else if (complete) begin
        addr_ff <= addr_ff + 13'h0001;
      end
    end
  end

  // shared memory window
  lpbp_lane_ram #(.DEPTH(MEM_DEPTH)) u_ram (
    .mclk  (mclk),
    .we    (writeHit && addr_ff[MEM_BIT]),
    .lanes (lanes_ff),
    .waddr (addr_ff[MA_W-1:0]),
    .wdata (bus.dq),
    .raddr (rdAddr[MA_W-1:0]),
    .rdata (ramRd)
  );

  // read data for the beat about to be presented
  assign rdAddr = addrPhase ? phaseAddr : addr_ff + 13'h0001;
  always_comb begin
    rdWord = 32'h0000_0000;
    if (rdAddr[MEM_BIT]) rdWord = ramRd;
    else if (rdAddr == CFG_IDX) rdWord = cfg_ff;
    else if (rdAddr == LIRQ_IDX) rdWord = lirq_ff;
    else if (rdAddr == HIRQ_IDX) rdWord = hirq_ff;
  end

  // configuration and interrupt control registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff  <= CFG_RESET;
      lirq_ff <= 32'h0000_0000;
      hirq_ff <= 32'h0000_0000;
    end else begin
      if (writeHit && addr_ff == CFG_IDX) begin
        cfg_ff <= mergeLanes(cfg_ff, bus.dq, lanes_ff);
      end
      if (writeHit && addr_ff == LIRQ_IDX && lanes_ff[1]) begin
        lirq_ff[IRQ_MASK_BIT] <= bus.dq[IRQ_MASK_BIT];
      end
      // write one clears; a host event in the same cycle wins
      if (hostEvent) begin
        lirq_ff[IRQ_STAT_BIT] <= 1'b1;
      end else if (writeHit && addr_ff == LIRQ_IDX && lanes_ff[0] && bus.dq[IRQ_STAT_BIT]) begin
        lirq_ff[IRQ_STAT_BIT] <= 1'b0;
      end
      if (writeHit && addr_ff == HIRQ_IDX && lanes_ff[1]) begin
        hirq_ff[IRQ_MASK_BIT] <= bus.dq[IRQ_MASK_BIT];
      end
      hirq_ff[IRQ_STAT_BIT] <= lvl(bus.irqIn, cfg_ff[CFG_IRQIN_HI]);
    end
  end

  // data bus, ready and interrupt drivers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dqOut_ff  <= 32'h0000_0000;
      dqOe_ff   <= 1'b0;
      rdyVal_ff <= 1'b1;
      rdyOe_ff  <= 1'b0;
      irqVal_ff <= 1'b0;
      irqOe_ff  <= 1'b0;
      intaOe_ff <= 1'b0;
    end else begin
      if (addrPhase || complete) begin
        dqOut_ff <= rdWord;
      end
      dqOe_ff <= (nxt_state == DS_DATA) && !(addrPhase ? isWr : wr_ff)
                 && pciBusReset_n && !testFloat;
      rdyVal_ff <= lvl(nxt_state == DS_DATA, cfg_ff[CFG_RDY_HI]);
      rdyOe_ff  <= ((nxt_state == DS_DATA) || cfg_ff[CFG_RDY_DRV])
                   && !(testFloat && cfg_ff[CFG_TST_RDY]);
      irqVal_ff <= cfg_ff[CFG_IRQ_HI];
      irqOe_ff  <= lirq_ff[IRQ_STAT_BIT] && !lirq_ff[IRQ_MASK_BIT] && !testFloat;
      intaOe_ff <= hirq_ff[IRQ_STAT_BIT] && !hirq_ff[IRQ_MASK_BIT] && !testFloat;
    end
  end

  // clock and reset copies toward the local side
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clkCopy_ff   <= 3'h0;
      rstCopy_n_ff <= 1'b0;
      held_ff      <= 1'b1;
    end else begin
      clkCopy_ff   <= {3{pciBusClk}};
      rstCopy_n_ff <= pciBusReset_n;
      if (!pciBusReset_n) begin
        held_ff <= 1'b1;
      end else if (hostReleaseReset) begin
        held_ff <= 1'b0;
      end
    end
  end

  assign bus.devDqOut       = dqOut_ff;
  assign bus.devDqOe        = dqOe_ff;
  assign bus.rdyOutVal      = rdyVal_ff;
  assign bus.rdyOutOe       = rdyOe_ff;
  assign bus.irqOutVal      = irqVal_ff;
  assign bus.irqOutOe       = irqOe_ff;
  assign bus.heldResetOut   = held_ff;
  assign bus.heldResetOut_n = ~held_ff;
  assign busClockCopyOut    = clkCopy_ff;
  assign busResetCopyOut_n  = rstCopy_n_ff;
  assign intaOe             = intaOe_ff;
endmodule : lpbp_device

// File: design/lpbp_host.sv
`timescale 1ns/1ps
module lpbp_host
  import lpbp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  lpbp_if.host             bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  lpbp_host_state_t state_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        isWr_ff;
  logic [3:0]  lanes_ff;
  logic [3:0]  beats_ff;
  logic [12:0] addr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic        done_ff;
  logic [2:0]  pins_ff;
  logic        sel_ff, ale_ff, stb_ff, bl_ff, rin_ff, dqOe_ff;
  logic [31:0] dqOut_ff;

  logic apbWr, apbRd, go, beatDone, mapped;

  assign apbWr    = psel && penable && pready_ff && pwrite;
  assign apbRd    = psel && penable && !pready_ff && !pwrite;
  assign go       = apbWr && paddr == H_CMD && pwdata[0] && state_ff == HS_IDLE
                    && !bus.heldResetOut;
  assign beatDone = state_ff == HS_DATA && !bus.rdyLine;
  assign mapped   = paddr inside {H_CMD, H_ADDR, H_WDATA, H_RDATA, H_STAT, H_PINS};

  // apb slave: one wait state, answer on the second access edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !mapped;
      if (apbRd) begin
        case (paddr)
          H_CMD:   prdata_ff <= {20'h0, beats_ff, 2'h0, lanes_ff, isWr_ff, 1'b0};
          H_ADDR:  prdata_ff <= {19'h0, addr_ff};
          H_WDATA: prdata_ff <= wdata_ff;
          H_RDATA: prdata_ff <= rdata_ff;
          H_STAT:  prdata_ff <= {28'h0, bus.heldResetOut, !bus.irqLine, done_ff,
                                 state_ff != HS_IDLE};
          H_PINS:  prdata_ff <= {29'h0, pins_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // controller registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      isWr_ff  <= 1'b0;
      lanes_ff <= 4'hf;
      addr_ff  <= '0;
      wdata_ff <= 32'h0000_0000;
      pins_ff  <= 3'h0;
      done_ff  <= 1'b0;
    end else begin
      if (apbWr && paddr == H_CMD && state_ff == HS_IDLE) begin
        isWr_ff  <= pwdata[1];
        lanes_ff <= pwdata[5:2];
      end
      if (apbWr && paddr == H_ADDR) addr_ff <= pwdata[12:0];
      if (apbWr && paddr == H_WDATA) wdata_ff <= pwdata;
      if (apbWr && paddr == H_PINS) pins_ff <= pwdata[2:0];
      // completion wins over a write-one clear
      if (state_ff == HS_END) begin
        done_ff <= 1'b1;
      end else if (go || (apbWr && paddr == H_STAT && pwdata[1])) begin
        done_ff <= 1'b0;
      end
    end
  end

  // local bus master sequencer, default pin polarities
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= HS_IDLE;
      sel_ff   <= 1'b1;
      ale_ff   <= 1'b0;
      stb_ff   <= 1'b1;
      bl_ff    <= 1'b1;
      rin_ff   <= 1'b1;
      dqOe_ff  <= 1'b0;
      dqOut_ff <= 32'h0000_0000;
      beats_ff <= 4'h0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      case (state_ff)
        HS_IDLE: begin
          if (go) begin
            state_ff <= HS_ALE;
            sel_ff   <= 1'b0;
            ale_ff   <= 1'b1;
            beats_ff <= pwdata[11:8];
            dqOe_ff  <= pins_ff[1];
            dqOut_ff <= {17'h0, addr_ff, 2'h0};
          end
        end
        HS_ALE: begin
          state_ff <= HS_STB;
          ale_ff   <= 1'b0;
          stb_ff   <= 1'b0;
        end
        HS_STB: begin
          state_ff <= HS_DATA;
          stb_ff   <= 1'b1;
          rin_ff   <= 1'b0;
          bl_ff    <= beats_ff == 4'h0;
          dqOe_ff  <= isWr_ff;
          dqOut_ff <= wdata_ff;
        end
        HS_DATA: begin
          if (beatDone) begin
            rdata_ff <= bus.dq;
            if (beats_ff == 4'h0) begin
              state_ff <= HS_END;
              sel_ff   <= 1'b1;
              rin_ff   <= 1'b1;
              bl_ff    <= 1'b1;
              dqOe_ff  <= 1'b0;
            end else begin
              beats_ff <= beats_ff - 4'h1;
              bl_ff    <= beats_ff == 4'h1;
            end
          end
        end
        HS_END:  state_ff <= HS_IDLE;
        default: state_ff <= HS_IDLE;
      endcase
    end
  end

  assign bus.sel             = sel_ff;
  assign bus.ale             = ale_ff;
  assign bus.strobe          = stb_ff;
  assign bus.wrPin           = isWr_ff;
  assign bus.rdPin           = !isWr_ff;
  assign bus.burstLastIn     = bl_ff;
  assign bus.rdyIn           = rin_ff;
  assign bus.localByteLaneEn = ~lanes_ff;
  assign bus.adr             = addr_ff;
  assign bus.hostDqOut       = dqOut_ff;
  assign bus.hostDqOe        = dqOe_ff;
  assign bus.irqIn           = !pins_ff[0];
  assign bus.testMode        = pins_ff[2];
  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
endmodule : lpbp_host

// File: tb/lpbp_monitor.sv
`timescale 1ns/1ps
module lpbp_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sel,
  input wire logic strobe,
  input wire logic rdPin,
  input wire logic burstLastIn,
  input wire logic rdyIn,
  input wire logic testMode,
  input wire logic hostDqOe,
  input wire logic devDqOe,
  input wire logic rdyOutVal,
  input wire logic rdyOutOe,
  input wire logic irqOutVal,
  input wire logic irqOutOe,
  input wire logic heldResetOut,
  input wire logic heldResetOut_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // data bus only driven inside a selected read beat
  dq_owner_a: assert property (devDqOe |-> !sel && rdyOutOe && !hostDqOe)
    else $error("data bus driven outside a read");
  // ready drives only its active low level
  rdy_level_a: assert property (rdyOutOe |-> !rdyOutVal)
    else $error("ready driven inactive");
  // strobe with select starts the access
  rdy_start_a: assert property ($fell(strobe) && !sel |=> rdyOutOe)
    else $error("no ready after strobe");
  // last beat releases ready
  rdy_end_a: assert property (rdyOutOe && !rdyIn && burstLastIn |=> !rdyOutOe)
    else $error("ready kept after last beat");
  // middle beats keep ready
  rdy_burst_a: assert property (rdyOutOe && !rdyIn && !burstLastIn && !sel |=> rdyOutOe)
    else $error("ready lost inside burst");
  // both held reset polarities agree
  held_pair_a: assert property (heldResetOut_n == !heldResetOut)
    else $error("held reset pair disagrees");
  // irq out drives only its active low level
  irq_level_a: assert property (irqOutOe |-> !irqOutVal)
    else $error("irq driven inactive");
  // test mode floats data and irq
  test_float_a: assert property (testMode && !rdPin ##1 testMode && !rdPin
    |-> !devDqOe && !irqOutOe)
    else $error("output driven in test mode");
  // dropped select ends the access
  sel_drop_a: assert property ($rose(sel) |=> !rdyOutOe && !devDqOe)
    else $error("access kept after select");
endmodule : lpbp_monitor

// File: tb/lpbp_tb.sv
`timescale 1ns/1ps
module lpbp_tb
  import lpbp_pkg::*;
;
  logic        mclk;
  logic        reset_n;
  logic        pciBusClk;
  logic        pciBusReset_n;
  logic        hostEvent;
  logic        hostReleaseReset;
  logic [2:0]  busClockCopyOut;
  logic        busResetCopyOut_n;
  logic        intaOe;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        er;
  int          numErrors;
  int          checksDone;

  lpbp_if bus ();
  lpbp_device #(.MEM_DEPTH(64)) lpbp_device_i (.mclk(mclk), .reset_n(reset_n), .bus(bus),
    .pciBusClk(pciBusClk), .pciBusReset_n(pciBusReset_n), .hostEvent(hostEvent),
    .hostReleaseReset(hostReleaseReset), .busClockCopyOut(busClockCopyOut),
    .busResetCopyOut_n(busResetCopyOut_n), .intaOe(intaOe));
  lpbp_host lpbp_host_i (.mclk(mclk), .reset_n(reset_n), .bus(bus), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  lpbp_monitor lpbp_monitor_i (.mclk(mclk), .reset_n(reset_n), .sel(bus.sel),
    .strobe(bus.strobe), .rdPin(bus.rdPin), .burstLastIn(bus.burstLastIn),
    .rdyIn(bus.rdyIn), .testMode(bus.testMode), .hostDqOe(bus.hostDqOe),
    .devDqOe(bus.devDqOe), .rdyOutVal(bus.rdyOutVal), .rdyOutOe(bus.rdyOutOe),
    .irqOutVal(bus.irqOutVal), .irqOutOe(bus.irqOutOe), .heldResetOut(bus.heldResetOut),
    .heldResetOut_n(bus.heldResetOut_n));

  // clock
  always #5 mclk = ~mclk;

  // one apb transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // one local bus order, waits for done, then fetches read data
  task lop(input logic [12:0] a, input logic [31:0] d, input logic [11:0] c);
    apb(1'b1, H_ADDR, 32'(a));
    apb(1'b1, H_WDATA, d);
    apb(1'b1, H_CMD, 32'(c));
    do begin
      apb(1'b0, H_STAT, 32'h0);
    end while (rd[1] !== 1'b1);
    apb(1'b0, H_RDATA, 32'h0);
  endtask : lop

  // compare a value
  task chk(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e) begin
      numErrors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // pulse the host event
  task evt;
    hostEvent <= 1'b1;
    @(posedge mclk);
    hostEvent <= 1'b0;
  endtask : evt

  // verdict
  task endSim;
    if (numErrors == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : endSim

  // watchdog
  initial begin
    #300us;
    numErrors++;
    endSim();
  end

  // main sequence
  initial begin
    {mclk, reset_n, pciBusClk, pciBusReset_n, hostEvent, hostReleaseReset} = 6'h0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    numErrors = 0;
    checksDone = 0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, H_STAT, 32'h0);
    chk(32'(rd[3]), 32'h1);
    chk(32'(busResetCopyOut_n), 32'h0);
    apb(1'b1, H_CMD, 32'h3f);
    apb(1'b0, H_STAT, 32'h0);
    chk(32'(rd[1:0]), 32'h0);
    pciBusReset_n <= 1'b1;
    pciBusClk <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(32'(busResetCopyOut_n), 32'h1);
    chk(32'(busClockCopyOut), 32'h7);
    pciBusClk <= 1'b0;
    hostReleaseReset <= 1'b1;
    @(posedge mclk);
    hostReleaseReset <= 1'b0;
    @(posedge mclk);
    chk(32'(busClockCopyOut), 32'h0);
    apb(1'b0, H_STAT, 32'h0);
    chk(32'(rd[3]), 32'h0);
    // full word, then one lane
    lop(13'h1005, 32'h1234_5678, 12'h03f);
    lop(13'h1005, 32'h0, 12'h03d);
    chk(rd, 32'h1234_5678);
    lop(13'h1005, 32'haabb_ccdd, 12'h007);
    lop(13'h1005, 32'h0, 12'h03d);
    chk(rd, 32'h1234_56dd);
    lop(CFG_IDX, 32'h0, 12'h03d);
    chk(rd, CFG_RESET);
    // four beat bursts
    lop(13'h1010, 32'h0f0f_0f0f, 12'h33f);
    lop(13'h1013, 32'h0, 12'h03d);
    chk(rd, 32'h0f0f_0f0f);
    lop(13'h100f, 32'h0, 12'h33d);
    chk(rd, 32'h0f0f_0f0f);
    // multiplexed address with encoded byte lanes
    apb(1'b1, H_PINS, 32'h2);
    lop(CFG_IDX, 32'h0000_1200, 12'h03f);
    lop(CFG_IDX, 32'h0, 12'h03d);
    chk(rd, 32'h0000_1200);
    lop(13'h1020, 32'h5a5a_0001, 12'h03f);
    lop(13'h1005, 32'haabb_ccdd, 12'h02b);
    lop(13'h1020, 32'h0, 12'h03d);
    chk(rd, 32'h5a5a_0001);
    lop(13'h1005, 32'h0, 12'h03d);
    chk(rd, 32'h1234_ccdd);
    lop(CFG_IDX, 32'h0, 12'h03f);
    apb(1'b1, H_PINS, 32'h0);
    apb(1'b1, 8'h18, 32'h0);
    chk(32'(er), 32'h1);
    // irq in to bus interrupt, then masked
    apb(1'b1, H_PINS, 32'h1);
    repeat (3) @(posedge mclk);
    chk(32'(intaOe), 32'h1);
    lop(HIRQ_IDX, 32'h100, 12'h03f);
    repeat (3) @(posedge mclk);
    chk(32'(intaOe), 32'h0);
    apb(1'b1, H_PINS, 32'h0);
    // irq out, test float, clear, mask
    evt();
    lop(13'h1030, 32'h1, 12'h03f);
    apb(1'b0, H_STAT, 32'h0);
    chk(32'(rd[2]), 32'h1);
    apb(1'b1, H_PINS, 32'h4);
    apb(1'b0, H_STAT, 32'h0);
    chk(32'(rd[2]), 32'h0);
    apb(1'b1, H_PINS, 32'h0);
    lop(LIRQ_IDX, 32'h1, 12'h03f);
    apb(1'b0, H_STAT, 32'h0);
    chk(32'(rd[2]), 32'h0);
    lop(LIRQ_IDX, 32'h100, 12'h03f);
    evt();
    apb(1'b0, H_STAT, 32'h0);
    chk(32'(rd[2]), 32'h0);
    lop(LIRQ_IDX, 32'h0, 12'h03d);
    chk(rd, 32'h0000_0101);
    endSim();
  end
endmodule : lpbp_tb
